// ### design/nar_cfg.svh
`ifndef NAR_CFG_SVH
`define NAR_CFG_SVH
// How it works
// - A request is one 16-bit actuator handle, and 0x0000 or 0xffff never names an actuator.
// - The first answer byte is the result code, 0x80 when the handle names no actuator.
// - The answer carries an 8-bit value format: u8, s8, u16, s16, u32, s32 in that order.
// - The answer carries an 8-bit operating state from the nine listed codes in order.
// - While the setting still moves, change-in-progress is reported with both settings valid.
// - When settled, the current setting is returned in both setting fields.
// - In the other states the setting fields carry no meaning and the requester ignores them.
// - Disabled is reported only as set by enable control and then no readings are given; the code takes it from the state register, not from ctrlEn.
// - Unavailable is reported only as set by enable control and the requester ignores it; the code takes it from the state register, not from ctrlEn.
// - Condition unknown is reported whenever no valid setting can be obtained.
// - Failed is reported once the actuator can no longer produce a correct setting.
// - Initializing is reported while starting, and the requester ignores state meanwhile.
// - Winding down is reported while heading for disabled, failed or unavailable.
// - Under test is reported while the actuator is being tested.
// - Both settings take the width of the format code, target setting first.

`define NAR_ADDR_CTRL 8'h00
`define NAR_ADDR_HANDLE 8'h04
`define NAR_ADDR_FORMAT 8'h08
`define NAR_ADDR_STATE 8'h0c
`define NAR_ADDR_TARGET 8'h10
`define NAR_ADDR_CURRENT 8'h14
`define NAR_ADDR_IRQ_STATUS 8'h18
`define NAR_ADDR_IRQ_MASK 8'h1c
`define NAR_ADDR_LAST_HANDLE 8'h20
`define NAR_ADDR_REQ_COUNT 8'h24

`define NAR_IRQ_DONE 0
`define NAR_IRQ_BAD 1

`define NAR_HANDLE_NONE_LO 16'h0000
`define NAR_HANDLE_NONE_HI 16'hffff
`define NAR_CODE_SUCCESS 8'h00
`define NAR_CODE_BAD_HANDLE 8'h80
`define NAR_HANDLE_RESET 16'h0001
`endif

// ### design/nar_pkg.sv
package nar_pkg;
  typedef enum logic [7:0] {
    NAR_FMT_U8, NAR_FMT_S8, NAR_FMT_U16, NAR_FMT_S16, NAR_FMT_U32, NAR_FMT_S32
  } nar_format_t;

  typedef enum logic [7:0] {
    NAR_ON_CHANGE_IN_PROGRESS, NAR_ON_SETTLED, NAR_DISABLED, NAR_UNAVAILABLE,
    NAR_CONDITION_UNKNOWN, NAR_FAILED, NAR_INITIALIZING, NAR_WINDING_DOWN,
    NAR_UNDER_TEST
  } nar_op_state_t;

  typedef enum logic [1:0] {NAR_IDLE, NAR_HANDLE_HI, NAR_SEND} nar_fsm_t;

  typedef struct packed {
    nar_fsm_t fsm;
    logic [7:0] handleLo;
    logic [3:0] idx;
    logic [3:0] lastIdx;
    logic [7:0] code;
    logic [7:0] fmtSnap;
    logic [7:0] stateSnap;
    logic [31:0] pend;
    logic [31:0] pres;
    logic reqReady;
    logic rspValid;
    logic rspLast;
    logic [7:0] rspData;
    logic ctrlEn;
    logic [15:0] handle;
    logic [7:0] format;
    logic [7:0] opState;
    logic [31:0] target;
    logic [31:0] current;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic irq;
    logic [15:0] lastHandle;
    logic [15:0] reqCount;
    logic aSel;
    logic aWrite;
    logic [7:0] aAddr;
    logic [31:0] hrdata;
    logic hreadyout;
  } nar_state_t;
endpackage : nar_pkg

// ### design/nar_numeric_actuator_readback.sv
`timescale 1ns/1ps
`include "nar_cfg.svh"
module nar_numeric_actuator_readback (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic reqValid,
  input wire logic [7:0] reqByte,
  output logic reqReady,
  output logic rspValid,
  output logic [7:0] rspData,
  output logic rspLast,
  input wire logic rspReady,
  output logic irq
);
  nar_pkg::nar_state_t s;
  nar_pkg::nar_state_t next_s;

  // Bytes per setting for a format code; unknown codes fall back to 4
  function automatic logic [3:0] fmtBytes(input logic [7:0] f);
    if (f == nar_pkg::NAR_FMT_U8 || f == nar_pkg::NAR_FMT_S8) begin
      fmtBytes = 4'h1;
    end else if (f == nar_pkg::NAR_FMT_U16 || f == nar_pkg::NAR_FMT_S16) begin
      fmtBytes = 4'h2;
    end else begin
      fmtBytes = 4'h4;
    end
  endfunction : fmtBytes

  // Answer byte k: code, format, state, target bytes, current bytes
  function automatic logic [7:0] byteAt(
    input logic [3:0] k,
    input logic [7:0] code,
    input logic [7:0] f,
    input logic [7:0] st,
    input logic [31:0] pend,
    input logic [31:0] pres
  );
    logic [3:0] w;
    logic [3:0] j;
    logic [31:0] v;
    w = fmtBytes(f);
    j = 4'h0;
    v = 32'h0;
    if (k == 4'h0) begin
      byteAt = code;
    end else if (k == 4'h1) begin
      byteAt = f;
    end else if (k == 4'h2) begin
      byteAt = st;
    end else begin
      j = k - 4'h3;
      if (j < w) begin
        v = pend >> {j[1:0], 3'h0};
      end else begin
        j = j - w;
        v = pres >> {j[1:0], 3'h0};
      end
      byteAt = v[7:0];
    end
  endfunction : byteAt

  always_comb begin
    logic [15:0] h;
    logic found;
    logic [7:0] st;
    logic [3:0] nextIdx;
    logic [1:0] setEv;
    logic [3:0] wBytes;
    h = 16'h0;
    wBytes = fmtBytes(s.format);
    found = 1'b0;
    st = 8'h0;
    nextIdx = 4'h0;
    setEv = 2'h0;
    next_s = s;

    // AHB-Lite: address phase captured, read data ready at data phase
    next_s.hreadyout = 1'b1;
    next_s.aSel = hsel && htrans[1] && hready;
    next_s.aWrite = hwrite;
    next_s.aAddr = haddr[7:0];
    next_s.hrdata = 32'h0;
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[7:0])
        `NAR_ADDR_CTRL: next_s.hrdata = {31'h0, s.ctrlEn};
        `NAR_ADDR_HANDLE: next_s.hrdata = {16'h0, s.handle};
        `NAR_ADDR_FORMAT: next_s.hrdata = {24'h0, s.format};
        `NAR_ADDR_STATE: next_s.hrdata = {24'h0, s.opState};
        `NAR_ADDR_TARGET: next_s.hrdata = s.target;
        `NAR_ADDR_CURRENT: next_s.hrdata = s.current;
        `NAR_ADDR_IRQ_STATUS: next_s.hrdata = {30'h0, s.irqStatus};
        `NAR_ADDR_IRQ_MASK: next_s.hrdata = {30'h0, s.irqMask};
        `NAR_ADDR_LAST_HANDLE: next_s.hrdata = {16'h0, s.lastHandle};
        `NAR_ADDR_REQ_COUNT: next_s.hrdata = {16'h0, s.reqCount};
        default: next_s.hrdata = 32'h0;
      endcase
    end
    if (s.aSel && s.aWrite) begin
      unique case (s.aAddr)
        `NAR_ADDR_CTRL: next_s.ctrlEn = hwdata[0];
        `NAR_ADDR_HANDLE: next_s.handle = hwdata[15:0];
        `NAR_ADDR_FORMAT: next_s.format = hwdata[7:0];
        `NAR_ADDR_STATE: next_s.opState = hwdata[7:0];
        `NAR_ADDR_TARGET: next_s.target = hwdata;
        `NAR_ADDR_CURRENT: next_s.current = hwdata;
        `NAR_ADDR_IRQ_STATUS: next_s.irqStatus = s.irqStatus & ~hwdata[1:0];
        `NAR_ADDR_IRQ_MASK: next_s.irqMask = hwdata[1:0];
        default: next_s.irqMask = s.irqMask;
      endcase
    end

    unique case (s.fsm)
      nar_pkg::NAR_IDLE: begin
        if (reqValid) begin
          next_s.handleLo = reqByte;
          next_s.fsm = nar_pkg::NAR_HANDLE_HI;
        end
      end
      nar_pkg::NAR_HANDLE_HI: begin
        if (reqValid) begin
          h = {reqByte, s.handleLo};
          found = s.ctrlEn && h == s.handle && h != `NAR_HANDLE_NONE_LO
            && h != `NAR_HANDLE_NONE_HI;
          // Codes past the table mean the state cannot be known
          st = s.opState > nar_pkg::NAR_UNDER_TEST ?
            nar_pkg::NAR_CONDITION_UNKNOWN : s.opState;
          next_s.code = found ? `NAR_CODE_SUCCESS : `NAR_CODE_BAD_HANDLE;
          next_s.fmtSnap = s.format;
          // States ..are set by software and passed through
          next_s.stateSnap = st;
          next_s.pend = 32'h0;
          next_s.pres = 32'h0;
          if (st == nar_pkg::NAR_ON_CHANGE_IN_PROGRESS) begin
            next_s.pend = s.target;
            next_s.pres = s.current;
          end else if (st == nar_pkg::NAR_ON_SETTLED) begin
            next_s.pend = s.current;
            next_s.pres = s.current;
          end
          next_s.lastIdx = found ?
            4'h2 + {wBytes[2:0], 1'b0} : 4'h0;
          next_s.idx = 4'h0;
          next_s.rspData = found ? `NAR_CODE_SUCCESS : `NAR_CODE_BAD_HANDLE;
          next_s.rspValid = 1'b1;
          next_s.rspLast = !found;
          next_s.reqReady = 1'b0;
          next_s.lastHandle = h;
          next_s.reqCount = s.reqCount + 16'h1;
          setEv[`NAR_IRQ_BAD] = !found;
          next_s.fsm = nar_pkg::NAR_SEND;
        end
      end
      nar_pkg::NAR_SEND: begin
        if (rspReady) begin
          if (s.rspLast) begin
            next_s.rspValid = 1'b0;
            next_s.rspLast = 1'b0;
            next_s.reqReady = 1'b1;
            setEv[`NAR_IRQ_DONE] = 1'b1;
            next_s.fsm = nar_pkg::NAR_IDLE;
          end else begin
            nextIdx = s.idx + 4'h1;
            next_s.idx = nextIdx;
            next_s.rspData = byteAt(nextIdx, s.code, s.fmtSnap, s.stateSnap,
              s.pend, s.pres);
            next_s.rspLast = nextIdx == s.lastIdx;
          end
        end
      end
    endcase

    // Event set wins over a same-cycle write-one clear
    next_s.irqStatus = next_s.irqStatus | setEv;
    next_s.irq = |(next_s.irqStatus & next_s.irqMask);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.reqReady <= 1'b1;
      s.hreadyout <= 1'b1;
      s.handle <= `NAR_HANDLE_RESET;
      s.opState <= nar_pkg::NAR_INITIALIZING;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign reqReady = s.reqReady;
  assign rspValid = s.rspValid;
  assign rspData = s.rspData;
  assign rspLast = s.rspLast;
  assign irq = s.irq;
endmodule : nar_numeric_actuator_readback

// ### testbench/nar_readback_monitor.sv
`timescale 1ns/1ps
module nar_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic [7:0] rspData,
  input wire logic rspLast,
  input wire logic rspReady
);
  logic [3:0] cnt;
  logic [7:0] fmt;
  logic gotLo;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Byte index within the answer, so fields can be checked by position
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 4'h0;
      fmt <= 8'h00;
      gotLo <= 1'b0;
    end else begin
      if (reqValid && reqReady) gotLo <= !gotLo;
      if (rspValid && rspReady) cnt <= rspLast ? 4'h0 : cnt + 4'h1;
      if (rspValid && rspReady && cnt == 4'h1) fmt <= rspData;
    end
  end
  a_first_code: assert property ($rose(rspValid) |->
    rspData == 8'h00 || rspData == 8'h80) else $error("bad first code");
  a_err_alone: assert property (rspValid && cnt == 4'h0 &&
    rspData == 8'h80 |-> rspLast) else $error("error answer too long");
  a_ok_continues: assert property (rspValid && cnt == 4'h0 &&
    rspData == 8'h00 |-> !rspLast) else $error("success answer cut");
  a_state_code: assert property (rspValid && cnt == 4'h2 |->
    rspData <= 8'h08) else $error("state code out of range");
  a_len_fmt: assert property (rspValid && rspLast && cnt != 4'h0 |->
    cnt == (fmt < 8'h02 ? 4'h4 : fmt < 8'h04 ? 4'h6 : 4'ha))
    else $error("answer length wrong for format");
  a_hold_byte: assert property (rspValid && !rspReady |=> rspValid &&
    $stable(rspData) && $stable(rspLast)) else $error("answer byte moved");
  a_answer_start: assert property (reqValid && reqReady && gotLo |=>
    rspValid && !reqReady) else $error("no answer after handle");
  a_ready_again: assert property (rspValid && rspReady && rspLast |=>
    !rspValid && reqReady) else $error("not ready after answer");
  c_long: cover property (rspValid && rspLast && cnt == 4'ha);
  c_bad: cover property (rspValid && rspData == 8'h80 && cnt == 4'h0);
  c_stall: cover property (rspValid && !rspReady);
endmodule : nar_monitor
bind nar_numeric_actuator_readback nar_monitor nar_monitor_inst (.clk(clk),
  .rst_b(rst_b), .reqValid(reqValid), .reqReady(reqReady),
  .rspValid(rspValid), .rspData(rspData), .rspLast(rspLast),
  .rspReady(rspReady));

// ### testbench/nar_requester.sv
`timescale 1ns/1ps
module nar_requester (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic stall,
  input wire logic [15:0] handle,
  input wire logic reqReady,
  output logic reqValid,
  output logic [7:0] reqByte,
  output logic rspReady
);
  logic hiNext;
  assign rspReady = !stall;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reqValid <= 1'b0;
      reqByte <= 8'h00;
      hiNext <= 1'b0;
    end else if (reqValid && reqReady) begin
      hiNext <= !hiNext;
      reqValid <= !hiNext;
      reqByte <= hiNext ? ~reqByte : handle[15:8];
    end else if (go && !reqValid) begin
      reqValid <= 1'b1;
      reqByte <= handle[7:0];
    end else if (!reqValid) begin
      reqByte <= ~reqByte; // Toggles when idle so a stale byte never matches
    end
  end
endmodule : nar_requester

// ### testbench/nar_testbench.sv
`timescale 1ns/1ps
`include "nar_cfg.svh"
module testbench;
  logic clk, rst_b, hsel, hwrite, hready, go, stall, reqValid, reqReady;
  logic rspValid, rspLast, rspReady, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rdv, tg, cu;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] reqByte, rspData;
  logic [15:0] h, hd;
  logic [7:0] q[$];
  logic [31:0] rv [11] = '{0, 1, 0, 6, 0, 0, 0, 0, 0, 0, 0};
  int n_fail, n_compared, seed;
  assign hready = hreadyout;
  nar_numeric_actuator_readback nar_numeric_actuator_readback_inst (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .reqValid(reqValid), .reqByte(reqByte), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .rspLast(rspLast),
    .rspReady(rspReady));
  nar_requester nar_requester_inst (.clk(clk), .rst_b(rst_b), .go(go),
    .stall(stall), .handle(h), .reqReady(reqReady), .reqValid(reqValid),
    .reqByte(reqByte), .rspReady(rspReady));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : ahb
  task automatic req(input logic [15:0] a, input logic ok, input int st);
    int w;
    logic [31:0] tv, cv;
    w = st % 6 < 2 ? 1 : st % 6 < 4 ? 2 : 4;
    tv = st == 0 ? tg : st == 1 ? cu : 32'h0;
    cv = st < 2 ? cu : 32'h0;
    q.push_back(ok ? 8'h00 : 8'h80);
    if (ok) begin
      q.push_back(8'(st % 6));
      q.push_back(st > 8 ? 8'h04 : 8'(st));
      for (int i = 0; i < 2 * w; i++)
        q.push_back(i < w ? tv[8*i+:8] : cv[8*(i-w)+:8]);
    end
    @(posedge clk);
    h <= a;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (q.size() != 0) @(posedge clk);
    @(posedge clk);
  endtask : req
  always @(posedge clk) stall <= 1'($random(seed));
  always @(posedge clk) if (rspValid === 1'b1 && rspReady === 1'b1) begin
    chk("answer byte", rspData, q.pop_front());
    chk("last flag", rspLast, q.size() == 0);
  end
  task automatic test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  initial begin
    #2000000;
    n_fail++;
    test_done;
  end
  initial begin
    seed = 32'h3b3e;
    {rst_b, hsel, hwrite, go, stall, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    h = 16'h0001;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      ahb(1'b0, 8'(4 * i), 32'h0);
      chk("reset reg", rdv, rv[i]);
    end
    $display("test reset done");
    req(16'h0001, 1'b0, 0);
    ahb(1'b0, `NAR_ADDR_IRQ_STATUS, 32'h0);
    chk("status", rdv, 32'h3);
    chk("irq masked", irq, 1'b0);
    ahb(1'b1, `NAR_ADDR_IRQ_MASK, 32'h3);
    @(posedge clk) #1 chk("irq on", irq, 1'b1);
    ahb(1'b1, `NAR_ADDR_IRQ_STATUS, 32'h3);
    @(posedge clk) #1 chk("irq off", irq, 1'b0);
    $display("test irq done");
    hd = 16'h1000 | 12'($random(seed));
    ahb(1'b1, `NAR_ADDR_CTRL, 32'h1);
    ahb(1'b1, `NAR_ADDR_HANDLE, {16'h0, hd});
    for (int s = 0; s < 10; s++) begin
      tg = $random(seed);
      cu = $random(seed);
      ahb(1'b1, `NAR_ADDR_TARGET, tg);
      ahb(1'b1, `NAR_ADDR_CURRENT, cu);
      ahb(1'b1, `NAR_ADDR_STATE, s);
      ahb(1'b1, `NAR_ADDR_FORMAT, s % 6);
      req(hd, 1'b1, s);
    end
    $display("test states done");
    req(hd + 16'h1, 1'b0, 0);
    ahb(1'b1, `NAR_ADDR_HANDLE, 32'hffff);
    req(16'hffff, 1'b0, 0);
    ahb(1'b1, `NAR_ADDR_HANDLE, 32'h0);
    req(16'h0000, 1'b0, 0);
    ahb(1'b0, `NAR_ADDR_REQ_COUNT, 32'h0);
    chk("request count", rdv, 32'he);
    ahb(1'b0, `NAR_ADDR_LAST_HANDLE, 32'h0);
    chk("last handle", rdv, 32'h0);
    chk("bus response", hresp, 1'b0);
    $display("test handles done");
    test_done;
  end
endmodule : testbench
